// [hdl/bus_trace_pkg.sv]
// Notes on behaviour
// R01: Comparator bytes reset to zero, always readable, writes ignored while armed.
// R02: FIFO high byte is read-only; reads zero in event-only modes.
// R03: High-byte read never moves the FIFO; low-byte read advances it.
// R04: Event-only modes store 8-bit data in the low half; read low repeatedly.
// R05: Low reads do not advance while armed; reader waits for run end.
// R06: Unarmed low read stores last fetched opcode address into last slot.
// R07: Control register readable and writable at any time.
// R08: Module enable refuses to set while secure; zero disables.
// R09: Arm write sets arm and flag; run end or clearing arm/enable stops it.
// R10: Tag select picks tag (1) or force (0) break; inert without break enable.
// R11: End trace breaks at trigger; begin trace breaks when FIFO fills.
// R12: Comparator A direction qualifier: 1 reads only, 0 writes only, if enabled.
// R13: Comparator B direction qualifier: 1 reads only, 0 writes only, if enabled.
// R14: Trigger register writable only unarmed; bits 4 and 5 read zero.
// R15: Execution qualify set: match counts only when opcode there is executed.
// R16: Begin select 1 starts storing at trigger; 0 fills circularly until trigger, except in event-only modes, which always begin trace.
// R17: Mode codes 0000..0110 as listed; 1001..1111 never trigger.
// R18: Mode 0111 inside A..B inclusive; 1000 below A or above B.
// R19: Match flags clear at run start, set on match since arming.
// R20: Armed flag mirrors arm bit; clears on full (begin) or trigger (end).
// R21: Valid count clears at run start, 0..8, never decrements on reads.
// R22: Break without background permit becomes a software interrupt request.
// R23: Nine register bytes sit in the normal memory map.
// R24: FIFO eight words of 16 bits; end trace keeps latest eight.
// R25: Data modes compare comparator B with data of the access matching A.
package bus_trace_pkg;
    localparam logic [3:0] OFS_CMP_A_HIGH = 4'h0;
    localparam logic [3:0] OFS_CMP_A_LOW = 4'h1;
    localparam logic [3:0] OFS_CMP_B_HIGH = 4'h2;
    localparam logic [3:0] OFS_CMP_B_LOW = 4'h3;
    localparam logic [3:0] OFS_FIFO_HIGH = 4'h4;
    localparam logic [3:0] OFS_FIFO_LOW = 4'h5;
    localparam logic [3:0] OFS_CONTROL = 4'h6;
    localparam logic [3:0] OFS_TRIGGER = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] TRIGGER_RESET = 8'h00;
    localparam logic [3:0] CNT_FULL = 4'h8;
    localparam logic [3:0] MODE_A_ONLY = 4'h0;
    localparam logic [3:0] MODE_A_OR_B = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B = 4'h2;
    localparam logic [3:0] MODE_EVENT_B = 4'h3;
    localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
    localparam logic [3:0] MODE_A_AND_B_DATA = 4'h5;
    localparam logic [3:0] MODE_A_NOT_B_DATA = 4'h6;
    localparam logic [3:0] MODE_INSIDE = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE = 4'h8;
    typedef struct packed {
        logic module_enable;
        logic arm;
        logic tag_select;
        logic break_request_enable;
        logic cmp_a_dir_value;
        logic cmp_a_dir_qualify;
        logic cmp_b_dir_value;
        logic cmp_b_dir_qualify;
    } control_t;
    typedef struct packed {
        logic execution_qualify;
        logic begin_select;
        logic [1:0] zero_bits;
        logic [3:0] trigger_mode_field;
    } trigger_t;
    typedef struct packed {
        logic match_a_flag;
        logic match_b_flag;
        logic run_active_flag;
        logic zero_bit;
        logic [3:0] valid_word_count;
    } status_t;
endpackage

// [hdl/bus_trace_trigger_debug.sv]
`default_nettype none
module bus_trace_trigger_debug
    import bus_trace_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int WIDTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_reg_sel,
    input wire logic [3:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_bus_valid,
    input wire logic [15:0] i_bus_addr,
    input wire logic [7:0] i_bus_data,
    input wire logic i_bus_rd,
    input wire logic i_fetch,
    input wire logic i_exec_valid,
    input wire logic [15:0] i_exec_addr,
    input wire logic i_secure,
    input wire logic i_background_permit,
    output logic o_break_req,
    output logic o_break_tag,
    output logic o_break_swi
);
    control_t ctrl_q;
    trigger_t trig_q;
    logic [15:0] cmp_a_q, cmp_b_q, last_fetch_q;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [3:0] cnt_q;
    logic af_q, bf_q, started_q;
    logic wr_any, rd_low, run_start, run_end;
    logic event_only, begin_trace, ev, ev_rd;
    logic [15:0] ev_addr;
    logic ma, mb, data_b, trig, store, fills;
    logic [WIDTH-1:0] store_word;
    control_t wctrl;

    assign wr_any = i_reg_sel & i_reg_wr;
    assign rd_low = i_reg_sel & i_reg_rd & (i_reg_addr == OFS_FIFO_LOW);
    assign wctrl = control_t'(i_reg_wdata);
    assign run_start = wr_any & (i_reg_addr == OFS_CONTROL) & wctrl.arm & ~ctrl_q.arm
        & (ctrl_q.module_enable | ~i_secure) & wctrl.module_enable;

    // Comparator value registers, frozen while a run is active
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            cmp_a_q <= {CMP_RESET, CMP_RESET}; // [R01]
            cmp_b_q <= {CMP_RESET, CMP_RESET};
        end else if (wr_any && !ctrl_q.arm) begin // [R01]
            if (i_reg_addr == OFS_CMP_A_HIGH) cmp_a_q[15:8] <= i_reg_wdata;
            if (i_reg_addr == OFS_CMP_A_LOW) cmp_a_q[7:0] <= i_reg_wdata;
            if (i_reg_addr == OFS_CMP_B_HIGH) cmp_b_q[15:8] <= i_reg_wdata;
            if (i_reg_addr == OFS_CMP_B_LOW) cmp_b_q[7:0] <= i_reg_wdata;
        end
    end

    // Control register; arm falls on run completion or when enable drops
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            ctrl_q <= control_t'(CONTROL_RESET);
        end else if (wr_any && i_reg_addr == OFS_CONTROL) begin // [R07]
            ctrl_q <= wctrl;
            ctrl_q.module_enable <= wctrl.module_enable & (ctrl_q.module_enable | ~i_secure); // [R08]
            ctrl_q.arm <= wctrl.arm & wctrl.module_enable & (ctrl_q.module_enable | ~i_secure); // [R09]
        end else if (run_end) begin
            ctrl_q.arm <= 1'b0; // [R09] [R20]
        end
    end

    // Trigger register; a write during a run would corrupt the sequence
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            trig_q <= trigger_t'(TRIGGER_RESET);
        end else if (wr_any && i_reg_addr == OFS_TRIGGER && !ctrl_q.arm) begin // [R14]
            trig_q <= trigger_t'(i_reg_wdata);
            trig_q.zero_bits <= 2'b00; // [R14]
        end
    end

    assign event_only = (trig_q.trigger_mode_field == MODE_EVENT_B)
        | (trig_q.trigger_mode_field == MODE_A_THEN_EVENT_B);
    assign begin_trace = trig_q.begin_select | event_only; // [R16]
    assign ev = ctrl_q.arm & (trig_q.execution_qualify ? i_exec_valid : i_bus_valid); // [R15]
    assign ev_addr = trig_q.execution_qualify ? i_exec_addr : i_bus_addr; // [R15]
    assign ev_rd = trig_q.execution_qualify | i_bus_rd;
    assign ma = ev & (ev_addr == cmp_a_q)
        & (!ctrl_q.cmp_a_dir_qualify | (ctrl_q.cmp_a_dir_value == ev_rd)); // [R12]
    assign mb = ev & (ev_addr == cmp_b_q)
        & (!ctrl_q.cmp_b_dir_qualify | (ctrl_q.cmp_b_dir_value == ev_rd)); // [R13]
    assign data_b = ma & (i_bus_data == cmp_b_q[7:0]); // [R25]

    always_comb begin
        trig = 1'b0;
        unique case (trig_q.trigger_mode_field) // [R17]
            MODE_A_ONLY: trig = ma;
            MODE_A_OR_B: trig = ma | mb;
            MODE_A_THEN_B: trig = af_q & mb;
            MODE_EVENT_B: trig = mb;
            MODE_A_THEN_EVENT_B: trig = af_q & mb;
            MODE_A_AND_B_DATA: trig = data_b; // [R25]
            MODE_A_NOT_B_DATA: trig = ma & ~data_b;
            MODE_INSIDE: trig = ev & (ev_addr >= cmp_a_q) & (ev_addr <= cmp_b_q); // [R18]
            MODE_OUTSIDE: trig = ev & ((ev_addr < cmp_a_q) | (ev_addr > cmp_b_q)); // [R18]
            default: trig = 1'b0;
        endcase
    end

    // Event-only captures the bus byte; other modes log fetch addresses
    always_comb begin
        store = 1'b0;
        store_word = '0;
        if (event_only) begin
            store = trig; // [R04]
            store_word = {{(WIDTH-8){1'b0}}, i_bus_data};
        end else begin
            store = ctrl_q.arm & i_fetch & (!begin_trace | started_q); // [R16]
            store_word = WIDTH'(i_bus_addr);
        end
    end

    assign fills = store & (cnt_q == CNT_FULL - 4'h1);
    assign run_end = ctrl_q.arm & (begin_trace ? fills : trig); // [R20]

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            started_q <= 1'b0;
        end else if (run_start) begin
            started_q <= 1'b0;
        end else if (ctrl_q.arm && trig) begin
            started_q <= 1'b1; // [R16]
        end
    end

    // Match flags: a match in the start cycle cannot occur, arm is still low
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            af_q <= 1'b0;
            bf_q <= 1'b0;
        end else if (run_start) begin
            af_q <= 1'b0; // [R19]
            bf_q <= 1'b0;
        end else begin
            if (ma) af_q <= 1'b1; // [R19]
            if (mb || data_b) bf_q <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            cnt_q <= 4'h0;
        end else if (run_start) begin
            cnt_q <= 4'h0; // [R21]
        end else if (store && cnt_q != CNT_FULL) begin
            cnt_q <= cnt_q + 4'h1; // [R21]
        end
    end

    // Shift FIFO: newest enters the last slot, reader sees slot zero
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
        end else if (store || (rd_low && !ctrl_q.arm)) begin // [R05] [R24]
            for (int i = 0; i < DEPTH - 1; i++) mem_q[i] <= mem_q[i+1];
            mem_q[DEPTH-1] <= store ? store_word : WIDTH'(last_fetch_q); // [R06] [R03]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            last_fetch_q <= 16'h0000;
        end else if (i_fetch) begin
            last_fetch_q <= i_bus_addr;
        end
    end

    // Break request, one cycle, type captured with it
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_break_req <= 1'b0;
            o_break_tag <= 1'b0;
            o_break_swi <= 1'b0;
        end else begin
            o_break_req <= run_end & ctrl_q.break_request_enable; // [R11]
            if (run_end && ctrl_q.break_request_enable) begin
                o_break_tag <= ctrl_q.tag_select; // [R10]
                o_break_swi <= ~i_background_permit; // [R22]
            end
        end
    end

    // Register readback, one cycle after the read strobe
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_sel && i_reg_rd) begin
            unique case (i_reg_addr) // [R23]
                OFS_CMP_A_HIGH: o_reg_rdata <= cmp_a_q[15:8];
                OFS_CMP_A_LOW: o_reg_rdata <= cmp_a_q[7:0];
                OFS_CMP_B_HIGH: o_reg_rdata <= cmp_b_q[15:8];
                OFS_CMP_B_LOW: o_reg_rdata <= cmp_b_q[7:0];
                OFS_FIFO_HIGH: o_reg_rdata <= event_only ? 8'h00 : mem_q[0][15:8]; // [R02]
                OFS_FIFO_LOW: o_reg_rdata <= mem_q[0][7:0];
                OFS_CONTROL: o_reg_rdata <= ctrl_q;
                OFS_TRIGGER: o_reg_rdata <= trig_q;
                OFS_STATUS: o_reg_rdata <= {af_q, bf_q, ctrl_q.arm, 1'b0, cnt_q}; // [R20]
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    a_cmp_freeze: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R01]
        ctrl_q.arm |=> $stable(cmp_a_q) && $stable(cmp_b_q))
        else $error("comparator changed while armed");
    a_secure_block: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R08]
        i_secure && !ctrl_q.module_enable |=> !ctrl_q.module_enable)
        else $error("enable set while secure");
    a_trig_freeze: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R14]
        ctrl_q.arm |=> $stable(trig_q) && trig_q.zero_bits == 2'b00)
        else $error("trigger register changed while armed");
    a_fifo_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R05]
        ctrl_q.arm && !store |=> $stable(mem_q[0]))
        else $error("fifo moved while armed without capture");
    a_profile_store: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R06]
        rd_low && !ctrl_q.arm |=> mem_q[DEPTH-1] == WIDTH'($past(last_fetch_q)))
        else $error("profile address not stored");
    a_cnt_range: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R21]
        cnt_q <= CNT_FULL)
        else $error("valid count out of range");

    a_cnt_clear: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R21]
        run_start |=> cnt_q == 4'h0)
        else $error("valid count not cleared at run start");

    // Reads must never pull the count down, the host tracks consumption
    a_cnt_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R21]
        !run_start && !store |=> $stable(cnt_q))
        else $error("valid count moved without capture");

    a_arm_start: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R09]
        run_start |=> ctrl_q.arm)
        else $error("arm not set by arming write");

    a_arm_needs_en: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R09]
        ctrl_q.arm |-> ctrl_q.module_enable)
        else $error("armed while module disabled");

    a_enable_drop: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R09]
        wr_any && i_reg_addr == OFS_CONTROL && !wctrl.module_enable |=> !ctrl_q.module_enable && !ctrl_q.arm)
        else $error("disable write did not stop the run");

    a_idle_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R09]
        !ctrl_q.arm |-> !ma && !mb && !trig)
        else $error("comparator active while not armed");

    a_store_stops: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R09]
        !ctrl_q.arm |-> !store)
        else $error("capture while not armed");

    a_hi_no_shift: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R03]
        i_reg_sel && i_reg_rd && i_reg_addr == OFS_FIFO_HIGH && !store |=> $stable(mem_q[0]))
        else $error("high byte read moved the fifo");

    a_low_shift: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R03]
        rd_low && !ctrl_q.arm |=> mem_q[0] == $past(mem_q[1]))
        else $error("low byte read did not advance the fifo");

    a_event_zero_high: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R02]
        i_reg_sel && i_reg_rd && i_reg_addr == OFS_FIFO_HIGH && event_only |=> o_reg_rdata == 8'h00)
        else $error("fifo high byte not zero in event mode");

    a_status_zero: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R20]
        i_reg_sel && i_reg_rd && i_reg_addr == OFS_STATUS |=> o_reg_rdata[4] == 1'b0)
        else $error("status spare bit not zero");

    a_trig_zero_bits: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R14]
        trig_q.zero_bits == 2'b00)
        else $error("trigger spare bits not zero");

    a_no_trig_code: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R17]
        trig_q.trigger_mode_field > MODE_OUTSIDE |-> !trig)
        else $error("unused mode code produced a trigger");

    a_a_only: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R17]
        trig_q.trigger_mode_field == MODE_A_ONLY |-> trig == ma)
        else $error("a-only mode trigger differs from match a");

    a_dir_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R12]
        ctrl_q.cmp_a_dir_qualify && ma |-> ctrl_q.cmp_a_dir_value == ev_rd)
        else $error("comparator a matched wrong direction");

    a_dir_b: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R13]
        ctrl_q.cmp_b_dir_qualify && mb |-> ctrl_q.cmp_b_dir_value == ev_rd)
        else $error("comparator b matched wrong direction");

    // Bus accesses alone must not trigger when execution qualifies
    a_exec_qual: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R15]
        trig_q.execution_qualify && !i_exec_valid |-> !ma && !mb)
        else $error("match without execution");

    a_inside: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R18]
        trig_q.trigger_mode_field == MODE_INSIDE && trig |-> ev_addr >= cmp_a_q && ev_addr <= cmp_b_q)
        else $error("inside range trigger out of range");

    a_begin_wait: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R16]
        ctrl_q.arm && begin_trace && !event_only && !started_q |-> !store)
        else $error("begin trace stored before trigger");

    a_break_needs_en: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R10]
        !ctrl_q.break_request_enable |=> !o_break_req)
        else $error("break without break enable");

    a_break_tag: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R10]
        run_end && ctrl_q.break_request_enable |=> o_break_tag == $past(ctrl_q.tag_select))
        else $error("break type wrong");

    a_flag_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R19]
        af_q && !run_start |=> af_q)
        else $error("match flag lost during run");

    a_data_b: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R25]
        trig_q.trigger_mode_field == MODE_A_AND_B_DATA && trig |-> ma)
        else $error("data mode triggered without address a");

    a_begin_break: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R11]
        ctrl_q.arm && begin_trace && fills && ctrl_q.break_request_enable |=> o_break_req && !ctrl_q.arm)
        else $error("begin trace break missing at full");
    a_end_break: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R11]
        ctrl_q.arm && !begin_trace && trig |=> !ctrl_q.arm ##0 o_break_req == $past(ctrl_q.break_request_enable))
        else $error("end trace did not stop at trigger");
    a_flag_clear: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R19]
        run_start |=> !af_q && !bf_q)
        else $error("match flags not cleared at run start");
    a_swi_kind: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // [R22]
        run_end && ctrl_q.break_request_enable |=> o_break_swi == !$past(i_background_permit))
        else $error("break kind wrong");
    c_end_trace: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        ctrl_q.arm && !begin_trace && trig);
    c_begin_full: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        ctrl_q.arm && begin_trace && fills);
    c_event_store: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        event_only && store);
    c_profile_read: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        rd_low && !ctrl_q.arm);
    c_exec_trigger: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        trig_q.execution_qualify && trig);
endmodule // bus_trace_trigger_debug
`default_nettype wire

// [tb/cpu_bus_model.sv]
`default_nettype none
module cpu_bus_model (
    input wire logic i_ref_clk,
    output logic o_bus_valid,
    output logic [15:0] o_bus_addr,
    output logic [7:0] o_bus_data,
    output logic o_bus_rd,
    output logic o_fetch,
    output logic o_exec_valid,
    output logic [15:0] o_exec_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_bus_valid = 1'b0;
        o_bus_addr = 16'h0000;
        o_bus_data = 8'h00;
        o_bus_rd = 1'b1;
        o_fetch = 1'b0;
        o_exec_valid = 1'b0;
        o_exec_addr = 16'h0000;
    end
    // Idle cycles show inverted values so a stale address never matches by luck
    task automatic access(input logic [15:0] a, input logic [7:0] d, input logic rd, input logic f);
        @(posedge i_ref_clk);
        o_bus_valid <= 1'b1;
        o_bus_addr <= a;
        o_bus_data <= d;
        o_bus_rd <= rd;
        o_fetch <= f;
        @(posedge i_ref_clk);
        o_bus_valid <= 1'b0;
        o_fetch <= 1'b0;
        o_bus_addr <= ~a;
        o_bus_data <= ~d;
        o_exec_valid <= f;
        o_exec_addr <= a;
        @(posedge i_ref_clk);
        o_exec_valid <= 1'b0;
        o_exec_addr <= ~a;
    endtask
endmodule // cpu_bus_model
`default_nettype wire

// [tb/bus_trace_trigger_debug_tb.sv]
`default_nettype none
module bus_trace_trigger_debug_tb
    import bus_trace_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [3:0] a; logic [7:0] v; logic chk; } note_t;
    logic ref_clk = 1'b0;
    logic nrst, reg_sel, reg_wr, reg_rd, secure, permit;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, bus_data;
    logic bus_valid, bus_rd, fetch, exec_valid, brk_req, brk_tag, brk_swi;
    logic [15:0] bus_addr, exec_addr, cmp_a;
    logic [15:0] f [4];
    logic [7:0] d [8];
    logic rd_seen = 1'b0;
    note_t rd_notes[$];
    logic [1:0] brk_notes[$];
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;

    always #5 ref_clk = ~ref_clk;

    cpu_bus_model cpu_u (.i_ref_clk(ref_clk), .o_bus_valid(bus_valid), .o_bus_addr(bus_addr),
        .o_bus_data(bus_data), .o_bus_rd(bus_rd), .o_fetch(fetch), .o_exec_valid(exec_valid),
        .o_exec_addr(exec_addr));
    bus_trace_trigger_debug dut_u (.i_ref_clk(ref_clk), .i_nrst(nrst), .i_reg_sel(reg_sel),
        .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata),
        .o_reg_rdata(reg_rdata), .i_bus_valid(bus_valid), .i_bus_addr(bus_addr), .i_bus_data(bus_data),
        .i_bus_rd(bus_rd), .i_fetch(fetch), .i_exec_valid(exec_valid), .i_exec_addr(exec_addr),
        .i_secure(secure), .i_background_permit(permit), .o_break_req(brk_req),
        .o_break_tag(brk_tag), .o_break_swi(brk_swi));

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_sel <= 1'b1;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_sel <= 1'b0;
        reg_wr <= 1'b0;
    endtask

    // Stale reads still take a note so the queue stays aligned with the bus
    task automatic rd(input logic [3:0] a, input logic [7:0] v, input logic chk = 1'b1);
        @(posedge ref_clk);
        reg_sel <= 1'b1;
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_notes.push_back('{a, v, chk});
        @(posedge ref_clk);
        reg_sel <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    always @(posedge ref_clk) begin : mon
        note_t n;
        logic [1:0] b;
        rd_seen <= reg_sel & reg_rd;
        cycles++;
        if (rd_seen && rd_notes.size() != 0) begin
            n = rd_notes.pop_front();
            if (n.chk) begin
                num_checks++;
                if (reg_rdata !== n.v) begin
                    err_total++;
                    $display("[FAIL] reg %0d expected %h seen %h", n.a, n.v, reg_rdata);
                end
            end
        end
        if (nrst && brk_req !== 1'b0) begin
            num_checks++;
            b = (brk_notes.size() != 0) ? brk_notes.pop_front() : 2'bxx;
            if ({brk_tag, brk_swi} !== b) begin
                err_total++;
                $display("[FAIL] break tag_swi expected %b seen %b", b, {brk_tag, brk_swi});
            end
        end
        if (cycles == 3000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        nrst = 1'b0;
        reg_sel = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        secure = 1'b0;
        permit = 1'b0;
        void'($urandom(56266));
        cmp_a = 16'($urandom());
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(4'(i), 8'h00);
        end
        secure <= 1'b1;
        wr(OFS_CONTROL, 8'h80);
        rd(OFS_CONTROL, 8'h00);
        secure <= 1'b0;
        wr(OFS_STATUS, 8'hFF);
        rd(OFS_STATUS, 8'h00);
        wr(OFS_TRIGGER, 8'h30);
        rd(OFS_TRIGGER, 8'h00);
        wr(OFS_CMP_A_HIGH, cmp_a[15:8]);
        wr(OFS_CMP_A_LOW, cmp_a[7:0]);
        wr(OFS_CMP_B_HIGH, cmp_a[15:8] ^ 8'h80);
        wr(OFS_CMP_B_LOW, cmp_a[7:0]);
        rd(OFS_CMP_A_LOW, cmp_a[7:0]);
        rd(OFS_CMP_B_HIGH, cmp_a[15:8] ^ 8'h80);
        wr(OFS_CONTROL, 8'hF0);
        rd(OFS_STATUS, 8'h20);
        wr(OFS_CMP_A_HIGH, ~cmp_a[15:8]);
        wr(OFS_TRIGGER, 8'h05);
        rd(OFS_CMP_A_HIGH, cmp_a[15:8]);
        rd(OFS_TRIGGER, 8'h00);
        for (int i = 0; i < 3; i++) begin
            f[i] = cmp_a + 16'h0010 + 16'(i);
            cpu_u.access(f[i], 8'h00, 1'b1, 1'b1);
        end
        f[3] = f[2];
        brk_notes.push_back(2'b11);
        cpu_u.access(cmp_a, 8'h00, 1'b1, 1'b0);
        rd(OFS_STATUS, 8'h83);
        rd(OFS_CONTROL, 8'hB0);
        for (int i = 0; i < 5; i++) begin
            rd(OFS_FIFO_LOW, 8'h00, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            rd(OFS_FIFO_HIGH, f[i][15:8]);
            rd(OFS_FIFO_HIGH, f[i][15:8]);
            rd(OFS_FIFO_LOW, f[i][7:0]);
        end
        permit <= 1'b1;
        wr(OFS_CONTROL, 8'hDC);
        cpu_u.access(cmp_a, 8'h5A, 1'b0, 1'b0);
        brk_notes.push_back(2'b00);
        cpu_u.access(cmp_a, 8'h00, 1'b1, 1'b0);
        rd(OFS_STATUS, 8'h80);
        for (int m = 9; m < 16; m++) begin
            wr(OFS_CONTROL, 8'h00);
            wr(OFS_TRIGGER, 8'(m));
            wr(OFS_CONTROL, 8'hD0);
            cpu_u.access(cmp_a, 8'h00, 1'b1, 1'b0);
            rd(OFS_CONTROL, 8'hD0);
        end
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_TRIGGER, 8'h80);
        wr(OFS_CONTROL, 8'hC0);
        cpu_u.access(cmp_a, 8'h00, 1'b1, 1'b0);
        rd(OFS_STATUS, 8'h20);
        cpu_u.access(cmp_a, 8'h00, 1'b1, 1'b1);
        rd(OFS_STATUS, 8'h81);
        wr(OFS_TRIGGER, 8'h03);
        wr(OFS_CONTROL, 8'hC3);
        cpu_u.access(cmp_a ^ 16'h8000, 8'h5A, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            d[i] = 8'($urandom());
            cpu_u.access(cmp_a ^ 16'h8000, d[i], 1'b1, 1'b0);
        end
        rd(OFS_STATUS, 8'h48);
        rd(OFS_FIFO_HIGH, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd(OFS_FIFO_LOW, d[i]);
        end
        repeat (4) @(posedge ref_clk);
        num_checks++;
        if (brk_notes.size() + rd_notes.size() != 0) begin
            err_total++;
            $display("[FAIL] pending notes expected 0 seen %0d", brk_notes.size() + rd_notes.size());
        end
        end_of_test();
    end
endmodule // bus_trace_trigger_debug_tb
`default_nettype wire
